// >>> rtl/mphdc_top.sv
// Operation
// - current magnitude is level percent of the motor rated current
// - ten second period; on-time is duty percent of it, rest off
// - duty zero gives no current; duty hundred gives continuous current
// - preheating stays inactive unless level and duty are both nonzero
// - with auto input assigned, input starts preheat; run or deassert stops
// - without auto input, preheat starts after every stop or power-up
// - without auto input, current starts on the second clock edge after the drive stops
// - indication output high while preheating active, when assigned
`include "mphdc_map.svh"
`default_nettype none

module mphdc_top
  import mphdc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MPHDC_TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        drive_running,
  input  wire logic        preheat_input,
  output logic             preheat_current_on,
  output logic [15:0]      preheat_current_cmd,
  output logic             preheat_indication
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp_pct(input logic [15:0] v);
    clamp_pct = (v > `MPHDC_PCT_MAX) ? `MPHDC_PCT_MAX : v;
  endfunction

  function automatic logic [15:0] scale_pct(input logic [15:0] pct,
                                            input logic [15:0] full);
    logic [31:0] prod;
    prod = pct * full;
    scale_pct = 16'(prod / 32'(`MPHDC_PCT_MAX));
  endfunction

  function automatic logic [11:0] word_idx(input logic [31:0] a);
    word_idx = a[`MPHDC_ADDR_W-1:2];
  endfunction

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic [11:0] wr_idx_reg;
  logic [11:0] wr_idx_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [15:0] level_reg;
  logic [15:0] level_next;
  logic [15:0] duty_reg;
  logic [15:0] duty_next;
  logic [15:0] rated_reg;
  logic [15:0] rated_next;
  logic [1:0]  ctrl_reg;
  logic [1:0]  ctrl_next;
  logic        in_range;
  logic        addr_phase;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // preheat state
  // ----------------------------------------------------------------
  mphdc_state_t state_reg;
  mphdc_state_t state_next;
  logic         on_reg;
  logic         on_next;
  logic [15:0]  cmd_reg;
  logic [15:0]  cmd_next;
  logic         ind_reg;
  logic         ind_next;
  logic         allowed;
  logic         auto_mode;

  mphdc_tick_if tick ();

  mphdc_period_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick.timer)
  );

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  // zero wait states: read data is latched in the address phase
  always_comb begin
    addr_phase   = hsel && htrans[1] && hready;
    in_range     = haddr[31:`MPHDC_ADDR_W] == '0;
    wr_pend_next = addr_phase && hwrite && in_range;
    wr_idx_next  = word_idx(haddr);
    level_next   = level_reg;
    duty_next    = duty_reg;
    rated_next   = rated_reg;
    ctrl_next    = ctrl_reg;
    rdata_next   = rdata_reg;
    status_word  = 32'h0000_0000;
    status_word[`MPHDC_ST_ACTIVE] = state_reg == MPHDC_HEAT;
    status_word[`MPHDC_ST_CUR_ON] = on_reg;
    status_word[`MPHDC_ST_RUN]    = drive_running;
    status_word[`MPHDC_ST_INPUT]  = preheat_input;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        `MPHDC_IDX_LEVEL: level_next = clamp_pct(hwdata[15:0]);
        `MPHDC_IDX_DUTY:  duty_next  = clamp_pct(hwdata[15:0]);
        `MPHDC_IDX_RATED: rated_next = hwdata[15:0];
        `MPHDC_IDX_CTRL:  ctrl_next  = hwdata[1:0];
        default:          ;
      endcase
    end
    if (addr_phase && !hwrite) begin
      if (!in_range) begin
        rdata_next = 32'h0000_0000;
      end else begin
        case (word_idx(haddr))
          `MPHDC_IDX_LEVEL:  rdata_next = {16'h0000, level_reg};
          `MPHDC_IDX_DUTY:   rdata_next = {16'h0000, duty_reg};
          `MPHDC_IDX_RATED:  rdata_next = {16'h0000, rated_reg};
          `MPHDC_IDX_CTRL:   rdata_next = {30'h0000_0000, ctrl_reg};
          `MPHDC_IDX_STATUS: rdata_next = status_word;
          default:           rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 12'h000;
      rdata_reg   <= 32'h0000_0000;
      level_reg   <= `MPHDC_LEVEL_RST;
      duty_reg    <= `MPHDC_DUTY_RST;
      rated_reg   <= `MPHDC_RATED_RST;
      ctrl_reg    <= `MPHDC_CTRL_RST;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg  <= wr_idx_next;
      rdata_reg   <= rdata_next;
      level_reg   <= level_next;
      duty_reg    <= duty_next;
      rated_reg   <= rated_next;
      ctrl_reg    <= ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // preheat control
  // ----------------------------------------------------------------
  // power-up counts as a stop, so the no-input mode is armed at reset
  always_comb begin
    auto_mode = ctrl_reg[`MPHDC_CTRL_AUTO_IN];
    allowed = (level_reg != 16'h0000) && (duty_reg != 16'h0000)
              && !drive_running;
    if (auto_mode) begin
      allowed = allowed && preheat_input;
    end
    state_next = state_reg;
    case (state_reg)
      MPHDC_IDLE: if (allowed) begin
        state_next = MPHDC_HEAT;
      end
      MPHDC_HEAT: if (!allowed) begin
        state_next = MPHDC_IDLE;
      end
      default: state_next = MPHDC_IDLE;
    endcase
    // timer held at zero until active
    tick.restart = state_reg != MPHDC_HEAT;
    on_next  = (state_next == MPHDC_HEAT) && (state_reg == MPHDC_HEAT)
               && (16'(tick.step) < duty_reg);
    cmd_next = on_next ? scale_pct(level_reg, rated_reg) : 16'h0000;
    ind_next = (state_next == MPHDC_HEAT)
               && ctrl_reg[`MPHDC_CTRL_IND_OUT];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= MPHDC_IDLE;
      on_reg    <= 1'b0;
      cmd_reg   <= 16'h0000;
      ind_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      on_reg    <= on_next;
      cmd_reg   <= cmd_next;
      ind_reg   <= ind_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic hreadyout_reg;
  logic hresp_reg;

  // zero wait states and never an error, so both are constant flops;
  // ready resets high so the bus is never stalled around reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end
  end

  assign hreadyout           = hreadyout_reg;
  assign hresp               = hresp_reg;
  assign hrdata              = rdata_reg;
  assign preheat_current_on  = on_reg;
  assign preheat_current_cmd = cmd_reg;
  assign preheat_indication  = ind_reg;

endmodule

`default_nettype wire

// >>> rtl/mphdc_map.svh
`ifndef MPHDC_MAP_SVH
`define MPHDC_MAP_SVH

// ----------------------------------------------------------------
// register indices and address width
// ----------------------------------------------------------------
`define MPHDC_IDX_LEVEL      12'h248
`define MPHDC_IDX_DUTY       12'h249
`define MPHDC_IDX_RATED      12'h24C
`define MPHDC_IDX_CTRL       12'h24D
`define MPHDC_IDX_STATUS     12'h24E
`define MPHDC_ADDR_W         14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define MPHDC_CTRL_AUTO_IN   0
`define MPHDC_CTRL_IND_OUT   1
`define MPHDC_ST_ACTIVE      0
`define MPHDC_ST_CUR_ON      1
`define MPHDC_ST_RUN         2
`define MPHDC_ST_INPUT       3
`define MPHDC_LEVEL_RST      16'h0000
`define MPHDC_DUTY_RST       16'h0000
`define MPHDC_RATED_RST      16'h0000
`define MPHDC_CTRL_RST       2'h0
`define MPHDC_PCT_MAX        16'h0064

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MPHDC_CLK_HZ         10000000
`define MPHDC_PERIOD_S       10
`define MPHDC_STEPS          100
`define MPHDC_TICK_CYCLES    ((`MPHDC_PERIOD_S * `MPHDC_CLK_HZ) / `MPHDC_STEPS)
`define MPHDC_STEP_W         7

`endif

// >>> rtl/mphdc_pkg.sv
`default_nettype none

package mphdc_pkg;
  typedef enum logic {
    MPHDC_IDLE,
    MPHDC_HEAT
  } mphdc_state_t;
endpackage

`default_nettype wire

// >>> rtl/mphdc_tick_if.sv
`include "mphdc_map.svh"
`default_nettype none

interface mphdc_tick_if;
  logic                     restart;
  logic [`MPHDC_STEP_W-1:0] step;

  modport timer (input restart, output step);
  modport ctrl  (output restart, input step);
endinterface

`default_nettype wire

// >>> rtl/mphdc_period_timer.sv
`include "mphdc_map.svh"
`default_nettype none

module mphdc_period_timer #(
  parameter int unsigned TICK_CYCLES = `MPHDC_TICK_CYCLES
) (
  input  wire logic  clock,
  input  wire logic  rst_n,
  mphdc_tick_if.timer tick
);

  localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [CW-1:0] CYC_LAST = CW'(TICK_CYCLES - 1);
  localparam logic [`MPHDC_STEP_W-1:0] STEP_LAST =
    `MPHDC_STEP_W'(`MPHDC_STEPS - 1);

  logic [CW-1:0]            cyc_reg;
  logic [CW-1:0]            cyc_next;
  logic [`MPHDC_STEP_W-1:0] step_reg;
  logic [`MPHDC_STEP_W-1:0] step_next;

  // ----------------------------------------------------------------
  // one step is a hundredth of the period
  // ----------------------------------------------------------------
  always_comb begin
    cyc_next  = cyc_reg;
    step_next = step_reg;
    if (tick.restart) begin
      cyc_next  = '0;
      step_next = '0;
    end else if (cyc_reg == CYC_LAST) begin
      cyc_next  = '0;
      step_next = (step_reg == STEP_LAST) ? '0 :
                  step_reg + `MPHDC_STEP_W'(1);
    end else begin
      cyc_next = cyc_reg + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cyc_reg  <= '0;
      step_reg <= '0;
    end else begin
      cyc_reg  <= cyc_next;
      step_reg <= step_next;
    end
  end

  assign tick.step = step_reg;

endmodule

`default_nettype wire

// >>> dv/mphdc_motor.sv
`default_nettype none
// --------------------------------
// winding heat model
// --------------------------------
module mphdc_motor (
  input  wire logic clock,
  input  wire logic current_on,
  output var  int   heat
);
  timeunit 1ns;
  timeprecision 1ns;
  // one heat unit per energised cycle, so on-time can be totalled
  initial heat = 0;
  always @(posedge clock) begin
    if (current_on)
      heat <= heat + 1;
  end
endmodule
`default_nettype wire

// >>> dv/mphdc_chk.sv
`default_nettype none
module mphdc_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        drive_running,
  input wire logic        preheat_input,
  input wire logic        preheat_current_on,
  input wire logic [15:0] preheat_current_cmd,
  input wire logic        preheat_indication
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // --------------------------------
  // preheat output checks
  // --------------------------------
  sequence s_hold;
    (!drive_running && preheat_input) [*3];
  endsequence
  a_cmd_off_zero: assert property (
    !preheat_current_on |-> preheat_current_cmd == 16'h0000)
    else $error("command while off");
  a_run_ends_on: assert property (
    drive_running |=> !preheat_current_on) else $error("on while running");
  a_run_ends_ind: assert property (
    drive_running |=> !preheat_indication) else $error("ind while running");
  a_start_stopped: assert property (
    $rose(preheat_current_on) |-> !$past(drive_running, 2))
    else $error("current started while running");
  a_on_lasts: assert property (
    $rose(preheat_current_on) ##0 s_hold |-> preheat_current_on)
    else $error("on phase too short");
  a_on_after_ind: assert property (
    $rose(preheat_indication) && !drive_running && preheat_input
    |=> preheat_current_on) else $error("period not begun with on");
  a_ind_with_on: assert property (
    $fell(preheat_indication) |-> !preheat_current_on)
    else $error("current after deactivation");
  a_on_follows: assert property (
    $rose(preheat_current_on) && preheat_indication
    |-> $past(preheat_indication)) else $error("on before activation");
endmodule
bind mphdc_top mphdc_chk #(.TICK_CYCLES(TICK_CYCLES)) i_mphdc_chk (
  .clock(clock), .rst_n(rst_n), .drive_running(drive_running),
  .preheat_input(preheat_input), .preheat_current_on(preheat_current_on),
  .preheat_current_cmd(preheat_current_cmd),
  .preheat_indication(preheat_indication));
`default_nettype wire

// >>> dv/motor_preheat_dc_controller_tb.sv
`include "mphdc_map.svh"
`default_nettype none
module motor_preheat_dc_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0;
  logic        rst_n = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        run = 1;
  logic        pin = 1;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        on;
  logic        ind;
  logic [15:0] cmd;
  int          errors = 0;
  int          num_checks = 0;
  int          heat, rated, lvl, dty, n;
  always #50 clock = ~clock;
  mphdc_top #(.TICK_CYCLES(4)) i_mphdc_top (.clock(clock), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .drive_running(run), .preheat_input(pin), .preheat_current_on(on),
    .preheat_current_cmd(cmd), .preheat_indication(ind));
  mphdc_motor i_mphdc_motor (.clock(clock), .current_on(on), .heat(heat));
  // --------------------------------
  // bus and compare tasks
  // --------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] idx,
                     input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'h0};
    do @(posedge clock); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'h1);
    rd = hrdata;
    check({hreadyout, hresp}, 32'h2);
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    bus(1'h0, idx, 32'h0);
    check(rd, exp);
  endtask
  // drive held running while reprogramming, then one full period counted
  task automatic run_case();
    run <= 1'h1;
    bus(1'h1, `MPHDC_IDX_LEVEL, lvl);
    bus(1'h1, `MPHDC_IDX_DUTY, dty);
    @(posedge clock);
    run <= 1'h0;
    n = 0;
    while (ind !== 1'h1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    check(ind, lvl != 0 && dty != 0);
    n = heat;
    repeat (401) begin
      @(posedge clock);
      if (on === 1'h1)
        check(cmd, lvl * rated / 100);
    end
    check(heat - n, (lvl != 0 && dty != 0) ? dty * 4 : 0);
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    void'($urandom(32'h8601));
    repeat (20) @(posedge clock);
    rst_n <= 1'h1;
    rchk(`MPHDC_IDX_LEVEL, 32'h0);
    rchk(`MPHDC_IDX_DUTY, 32'h0);
    rchk(12'h3FF, 32'h0);
    bus(1'h1, `MPHDC_IDX_LEVEL, 32'hC8);
    rchk(`MPHDC_IDX_LEVEL, 32'h64);
    rated = $urandom_range(1000, 1);
    bus(1'h1, `MPHDC_IDX_RATED, rated);
    bus(1'h1, `MPHDC_IDX_CTRL, 32'h2);
    for (int i = 0; i < 5; i++) begin
      lvl = (i == 1) ? 0 : $urandom_range(100, 1);
      dty = (i == 0) ? 0 : (i == 2) ? 100 : (i == 4) ? 1
            : $urandom_range(99, 1);
      run_case();
    end
    pin <= 1'h0;
    bus(1'h1, `MPHDC_IDX_DUTY, 32'h64);
    bus(1'h1, `MPHDC_IDX_CTRL, 32'h3);
    repeat (3) @(posedge clock);
    check(on | ind, 1'h0);
    pin <= 1'h1;
    repeat (8) @(posedge clock);
    check(on & ind, 1'h1);
    pin <= 1'h0;
    repeat (2) @(posedge clock);
    check(on | ind, 1'h0);
    pin <= 1'h1;
    repeat (4) @(posedge clock);
    run <= 1'h1;
    repeat (2) @(posedge clock);
    check(on | ind, 1'h0);
    rchk(`MPHDC_IDX_RATED, rated);
    rchk(`MPHDC_IDX_CTRL, 32'h3);
    // indication left unassigned, level raised in small steps
    bus(1'h1, `MPHDC_IDX_CTRL, 32'h1);
    run <= 1'h0;
    for (int k = 1; k <= 10; k++) begin
      lvl = k * 10;
      bus(1'h1, `MPHDC_IDX_LEVEL, lvl);
      repeat (2) @(posedge clock);
      check(cmd, lvl * rated / 100);
    end
    check({on, ind}, 32'h2);
    rchk(`MPHDC_IDX_STATUS, 32'hB);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
